//--- csp_consts.vh
// Purpose: constants of the configurable serial port
// Assumes: 250 MHz pclk, APB register access
// Notes:   definitions only
`ifndef CSP_CONSTS_VH
`define CSP_CONSTS_VH
`define CSP_OFF_DATA    12'h000
`define CSP_OFF_CTRL    12'h004
`define CSP_OFF_BAUD    12'h008
`define CSP_OFF_STAT    12'h00c
// Control field positions
`define CSP_C_DBITS_LO  0
`define CSP_C_DBITS_HI  1
`define CSP_C_STOP2     2
`define CSP_C_PAR_LO    3
`define CSP_C_PAR_HI    5
`define CSP_C_FLOW_LO   6
`define CSP_C_FLOW_HI   7
`define CSP_C_FIFO      8
// Status bits that a write of one clears
`define CSP_S_PERR      3
`define CSP_S_FERR      4
`define CSP_S_OVR       5
// 8 data bits, 1 stop, no parity, RTS/CTS, buffers on
`define CSP_CTRL_RST    9'h143
// 250e6 / 115200 rounded to nearest
`define CSP_BAUD_RST    16'h087a
`define CSP_PAR_NONE    3'h0
`define CSP_PAR_ODD     3'h1
`define CSP_PAR_EVEN    3'h2
`define CSP_PAR_MARK    3'h3
`define CSP_PAR_SPACE   3'h4
`define CSP_FLOW_NONE   2'h0
`define CSP_FLOW_HW     2'h1
`define CSP_FLOW_SW     2'h2
`define CSP_XON         8'h11
`define CSP_XOFF        8'h13
`define CSP_DBITS_5     2'h0
`define CSP_DBITS_8     2'h3
`define CSP_FIFO_DEPTH  5'h10
`define CSP_FIFO_ONE    5'h01
// Stop length in half bit periods, less one
`define CSP_HALF_1      2'h1
`define CSP_HALF_15     2'h2
`define CSP_HALF_2      2'h3
`define CSP_ST_IDLE     3'h0
`define CSP_ST_START    3'h1
`define CSP_ST_DATA     3'h2
`define CSP_ST_PAR      3'h3
`define CSP_ST_STOP     3'h4
`endif

//--- csp_top.v
// Purpose: configurable asynchronous serial port with APB registers
// Assumes: one clock pclk, software writes the bit period in cycles
// Notes:   clk_en low freezes every flip-flop, bus included
`timescale 1ns/1ps
`default_nettype none
`include "csp_consts.vh"

module csp_fifo (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       en,
  input  wire [4:0] lim,
  input  wire       push,
  input  wire [7:0] din,
  input  wire       pop,
  output wire [7:0] dout,
  output wire       empty,
  output wire       full
);
  reg [7:0] mem_reg [0:15];
  reg [3:0] wp_reg;
  reg [3:0] rp_reg;
  reg [4:0] cnt_reg;
  wire      do_push;
  wire      do_pop;
  assign empty   = (cnt_reg == 5'h00);
  assign full    = (cnt_reg >= lim);
  assign dout    = mem_reg[rp_reg];
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  always @(posedge clk) begin
    if (en && do_push) begin
      mem_reg[wp_reg] <= din;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else if (en) begin
      if (do_push) begin
        wp_reg <= wp_reg + 4'h1;
      end
      if (do_pop) begin
        rp_reg <= rp_reg + 4'h1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 5'h01;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule

module csp_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxd,
  input  wire        cts_n,
  output reg         txd,
  output reg         rts_n
);
  reg  [8:0]  ctrl_reg;
  reg  [15:0] baud_reg;
  reg  [1:0]  rx_m_reg;
  reg  [1:0]  cts_m_reg;
  reg  [2:0]  tx_st_reg;
  reg  [15:0] tx_cnt_reg;
  reg  [2:0]  tx_idx_reg;
  reg  [1:0]  tx_half_reg;
  reg  [7:0]  tx_sh_reg;
  reg         tx_pb_reg;
  reg  [2:0]  rx_st_reg;
  reg  [15:0] rx_cnt_reg;
  reg  [2:0]  rx_idx_reg;
  reg  [7:0]  rx_sh_reg;
  reg         rx_x_reg;
  reg         perr_reg;
  reg         ferr_reg;
  reg         ovr_reg;
  reg         paused_reg;
  reg  [31:0] prdata_next;
  reg         hit;
  wire [1:0]  dbits  = ctrl_reg[`CSP_C_DBITS_HI:`CSP_C_DBITS_LO];
  wire [2:0]  par    = ctrl_reg[`CSP_C_PAR_HI:`CSP_C_PAR_LO];
  wire [1:0]  flow   = ctrl_reg[`CSP_C_FLOW_HI:`CSP_C_FLOW_LO];
  wire [15:0] half   = {1'b0, baud_reg[15:1]};
  wire [2:0]  last   = {1'b1, dbits};
  wire [7:0]  dmask  = 8'hff >> (`CSP_DBITS_8 - dbits);
  wire [4:0]  lim    = ctrl_reg[`CSP_C_FIFO] ? `CSP_FIFO_DEPTH
                                             : `CSP_FIFO_ONE;
  wire        rx_s   = rx_m_reg[1];
  wire        cts_s  = cts_m_reg[1];
  wire        setup  = psel & ~penable;
  wire        acc    = psel & penable & pready;
  wire        wr     = acc & pwrite;
  wire        rd     = acc & ~pwrite;
  wire        tx_push = wr && paddr == `CSP_OFF_DATA;
  wire        rx_pop  = rd && paddr == `CSP_OFF_DATA;
  wire [7:0]  tx_dout;
  wire        tx_empty;
  wire        tx_full;
  wire [7:0]  rx_dout;
  wire        rx_empty;
  wire        rx_full;
  wire        flow_ok = (flow == `CSP_FLOW_HW) ? ~cts_s :
                        (flow == `CSP_FLOW_SW) ? ~paused_reg : 1'b1;
  wire        tx_go   = (tx_st_reg == `CSP_ST_IDLE) & ~tx_empty & flow_ok;
  wire [7:0]  tx_d    = tx_dout & dmask;
  wire [1:0]  stop_h  = (dbits == `CSP_DBITS_5) ? `CSP_HALF_15 :
                        ctrl_reg[`CSP_C_STOP2] ? `CSP_HALF_2 :
                        `CSP_HALF_1;
  wire [15:0] tx_len  = (tx_st_reg == `CSP_ST_STOP) ? half : baud_reg;
  wire        tx_end  = (tx_cnt_reg == tx_len - 16'h0001);
  wire        rx_mid  = (rx_cnt_reg == half - 16'h0001);
  wire        rx_end  = (rx_cnt_reg == baud_reg - 16'h0001);
  wire [7:0]  rx_byte = rx_sh_reg >> (`CSP_DBITS_8 - dbits);
  wire        rx_ctl  = (flow == `CSP_FLOW_SW) &&
                        (rx_byte == `CSP_XON || rx_byte == `CSP_XOFF);
  wire        rx_done = (rx_st_reg == `CSP_ST_STOP) & rx_end;
  wire        rx_push = rx_done & rx_s & ~rx_ctl;
  reg         tx_pbit;
  reg         rx_pbad;

  csp_fifo u_txf (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (clk_en),
    .lim   (lim),
    .push  (tx_push),
    .din   (pwdata[7:0]),
    .pop   (tx_go),
    .dout  (tx_dout),
    .empty (tx_empty),
    .full  (tx_full)
  );

  csp_fifo u_rxf (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (clk_en),
    .lim   (lim),
    .push  (rx_push),
    .din   (rx_byte),
    .pop   (rx_pop),
    .dout  (rx_dout),
    .empty (rx_empty),
    .full  (rx_full)
  );

  always @* begin
    case (par)
      `CSP_PAR_ODD:   tx_pbit = ~(^tx_d);
      `CSP_PAR_EVEN:  tx_pbit = ^tx_d;
      `CSP_PAR_MARK:  tx_pbit = 1'b1;
      default:        tx_pbit = 1'b0;
    endcase
    case (par)
      `CSP_PAR_ODD:   rx_pbad = ~(rx_x_reg ^ rx_s);
      `CSP_PAR_EVEN:  rx_pbad = rx_x_reg ^ rx_s;
      `CSP_PAR_MARK:  rx_pbad = ~rx_s;
      `CSP_PAR_SPACE: rx_pbad = rx_s;
      default:        rx_pbad = 1'b0;
    endcase
  end

  always @* begin
    hit         = 1'b1;
    prdata_next = 32'h0000_0000;
    case (paddr)
      `CSP_OFF_DATA: prdata_next = {24'h000000, rx_dout};
      `CSP_OFF_CTRL: prdata_next = {23'h000000, ctrl_reg};
      `CSP_OFF_BAUD: prdata_next = {16'h0000, baud_reg};
      `CSP_OFF_STAT: prdata_next = {25'h0000000, paused_reg, ovr_reg,
                                    ferr_reg, perr_reg, rx_full,
                                    rx_empty, tx_full};
      default:       hit = 1'b0;
    endcase
  end

  // Registered answer: no wait state, pready high in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      ctrl_reg <= `CSP_CTRL_RST;
      baud_reg <= `CSP_BAUD_RST;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= setup ? prdata_next : 32'h0000_0000;
      if (wr && paddr == `CSP_OFF_CTRL) begin
        ctrl_reg <= pwdata[8:0];
      end
      // Divisor is round(pclk / rate); zero would stall the bit timer
      if (wr && paddr == `CSP_OFF_BAUD && pwdata[15:0] != 16'h0000) begin
        baud_reg <= pwdata[15:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m_reg  <= 2'b11;
      cts_m_reg <= 2'b11;
      rts_n     <= 1'b1;
      perr_reg  <= 1'b0;
      ferr_reg  <= 1'b0;
      ovr_reg   <= 1'b0;
      paused_reg <= 1'b0;
    end else if (clk_en) begin
      rx_m_reg  <= {rx_m_reg[0], rxd};
      cts_m_reg <= {cts_m_reg[0], cts_n};
      rts_n     <= (flow == `CSP_FLOW_HW) & rx_full;
      // Hardware set wins over a write-one clear in the same cycle
      if (rx_st_reg == `CSP_ST_PAR && rx_end && rx_pbad) begin
        perr_reg <= 1'b1;
      end else if (wr && paddr == `CSP_OFF_STAT && pwdata[`CSP_S_PERR]) begin
        perr_reg <= 1'b0;
      end
      if (rx_done && !rx_s) begin
        ferr_reg <= 1'b1;
      end else if (wr && paddr == `CSP_OFF_STAT && pwdata[`CSP_S_FERR]) begin
        ferr_reg <= 1'b0;
      end
      if (rx_push && rx_full) begin
        ovr_reg <= 1'b1;
      end else if (wr && paddr == `CSP_OFF_STAT && pwdata[`CSP_S_OVR]) begin
        ovr_reg <= 1'b0;
      end
      if (flow != `CSP_FLOW_SW) begin
        paused_reg <= 1'b0;
      end else if (rx_done && rx_s && rx_ctl) begin
        paused_reg <= (rx_byte == `CSP_XOFF);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg   <= `CSP_ST_IDLE;
      tx_cnt_reg  <= 16'h0000;
      tx_idx_reg  <= 3'h0;
      tx_half_reg <= 2'h0;
      tx_sh_reg   <= 8'h00;
      tx_pb_reg   <= 1'b0;
      txd         <= 1'b1;
    end else if (clk_en) begin
      tx_cnt_reg <= tx_end ? 16'h0000 : tx_cnt_reg + 16'h0001;
      case (tx_st_reg)
        `CSP_ST_IDLE: begin
          tx_cnt_reg <= 16'h0000;
          if (tx_go) begin
            tx_sh_reg <= tx_d;
            tx_pb_reg <= tx_pbit;
            tx_st_reg <= `CSP_ST_START;
            txd       <= 1'b0;
          end
        end
        `CSP_ST_START: begin
          if (tx_end) begin
            tx_idx_reg <= 3'h0;
            tx_st_reg  <= `CSP_ST_DATA;
            txd        <= tx_sh_reg[0];
          end
        end
        `CSP_ST_DATA: begin
          if (tx_end && tx_idx_reg == last) begin
            tx_half_reg <= 2'h0;
            tx_st_reg   <= (par == `CSP_PAR_NONE) ? `CSP_ST_STOP
                                                  : `CSP_ST_PAR;
            txd         <= (par == `CSP_PAR_NONE) | tx_pb_reg;
          end else if (tx_end) begin
            tx_idx_reg <= tx_idx_reg + 3'h1;
            tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
            txd        <= tx_sh_reg[1];
          end
        end
        `CSP_ST_PAR: begin
          if (tx_end) begin
            tx_st_reg <= `CSP_ST_STOP;
            txd       <= 1'b1;
          end
        end
        `CSP_ST_STOP: begin
          // Counted in half bits so that 1.5 stop needs no second timer
          if (tx_end) begin
            tx_half_reg <= tx_half_reg + 2'h1;
            if (tx_half_reg == stop_h) begin
              tx_st_reg <= `CSP_ST_IDLE;
            end
          end
        end
        default: begin
          tx_st_reg <= `CSP_ST_IDLE;
          txd       <= 1'b1;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg  <= `CSP_ST_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_idx_reg <= 3'h0;
      rx_sh_reg  <= 8'h00;
      rx_x_reg   <= 1'b0;
    end else if (clk_en) begin
      rx_cnt_reg <= rx_end ? 16'h0000 : rx_cnt_reg + 16'h0001;
      case (rx_st_reg)
        `CSP_ST_IDLE: begin
          rx_cnt_reg <= 16'h0000;
          if (!rx_s) begin
            rx_st_reg <= `CSP_ST_START;
          end
        end
        `CSP_ST_START: begin
          // Recheck at mid start bit rejects glitches on the line
          if (rx_mid) begin
            rx_cnt_reg <= 16'h0000;
            rx_idx_reg <= 3'h0;
            rx_x_reg   <= 1'b0;
            rx_st_reg  <= rx_s ? `CSP_ST_IDLE : `CSP_ST_DATA;
          end
        end
        `CSP_ST_DATA: begin
          if (rx_end) begin
            rx_sh_reg  <= {rx_s, rx_sh_reg[7:1]};
            rx_x_reg   <= rx_x_reg ^ rx_s;
            rx_idx_reg <= rx_idx_reg + 3'h1;
            if (rx_idx_reg == last) begin
              rx_st_reg <= (par == `CSP_PAR_NONE) ? `CSP_ST_STOP
                                                  : `CSP_ST_PAR;
            end
          end
        end
        `CSP_ST_PAR: begin
          if (rx_end) begin
            rx_st_reg <= `CSP_ST_STOP;
          end
        end
        `CSP_ST_STOP: begin
          if (rx_end) begin
            rx_st_reg <= `CSP_ST_IDLE;
          end
        end
        default: begin
          rx_st_reg <= `CSP_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- csp_monitor.sv
// Purpose: bus and line checks on csp_top ports
// Assumes: BAUD is 8 cycles before any frame is sent
// Notes:   bound to every csp_top instance
`timescale 1ns/1ps
`default_nettype none
module csp_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_answer: assert property (
    psel && !penable && clk_en |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_ready_cause: assert property (
    pready |-> $past(psel) && !$past(penable))
    else $error("ready without a setup cycle");
  a_err_quiet: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  a_data_idle: assert property (
    !pready |-> prdata == 32'h0)
    else $error("read data outside access cycle");
  a_low_bit: assert property (
    $fell(txd) |-> !txd [*8])
    else $error("low bit shorter than bit period");
  a_high_bit: assert property (
    $rose(txd) |-> txd [*8])
    else $error("high bit shorter than bit period");
  cover property ($fell(txd));
  cover property (pslverr);
  cover property (pready && prdata != 32'h0);
endmodule
bind csp_top csp_monitor csp_monitor_inst (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd));
`default_nettype wire

//--- csp_partner.sv
// Purpose: serial field device facing the port
// Assumes: bit period of 8 pclk cycles
// Notes:   line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module csp_partner (
  input  wire logic       pclk,
  input  wire logic       txd,
  input  wire logic [3:0] nbits,
  input  wire logic       pbit,
  output var  logic       rxd,
  output var  logic       got_v,
  output var  logic [8:0] got
);
  logic [8:0] g;
  initial begin
    rxd = 1'b1;
    got_v = 1'b0;
    got = 9'h0;
  end
  task automatic send(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (8) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  // Sample mid-bit; frame shape follows the bench's settings
  always begin
    @(negedge txd);
    g = 9'h0;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < nbits + pbit; i++) begin
      repeat (8) @(posedge pclk);
      g[i] = txd;
    end
    got <= g;
    got_v <= 1'b1;
    @(posedge pclk);
    got_v <= 1'b0;
  end
endmodule
`default_nettype wire

//--- csp_tb_top.sv
// Purpose: self-checking bench for csp_top
// Assumes: BAUD set to 8 cycles, partner at the serial side
// Notes:   clk_en stays high; freeze is not exercised
`timescale 1ns/1ps
`default_nettype none
`include "csp_consts.vh"
module csp_tb_top;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pb;
  logic        pready, pslverr, rxd, cts_n, txd, rts_n, got_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0]  got;
  logic [3:0]  nb;
  logic [32:0] exp_q[$];
  logic [8:0]  ser_q[$];
  int          fail_count = 0;
  int          total_checks = 0;
  csp_top csp_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));
  csp_partner csp_partner_inst (.pclk(pclk), .txd(txd), .nbits(nb),
    .pbit(pb), .rxd(rxd), .got_v(got_v), .got(got));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk(exp_q.pop_front(), {pslverr, prdata});
    // An unexpected frame can never match the impossible top bit
    if (got_v === 1'b1)
      chk(ser_q.size() ? {24'h0, ser_q.pop_front()} : 33'h1_0000_0000,
          {24'h0, got});
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    if (!w) exp_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(33'h0, {32'h0, n >= 20});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_ser;
    int n;
    n = 0;
    while (ser_q.size() > 0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chk(33'h0, {32'h0, n >= 4000});
    // Let the stop bit finish before any reconfiguration
    repeat (20) @(posedge pclk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #80000;
    chk(33'h0, 33'h1);
    test_done();
  end
  initial begin
    logic [7:0] r, b;
    logic [3:0] d;
    logic [2:0] p;
    logic       q;
    void'($urandom(32'hfcc9));
    {presetn, clk_en, psel, penable, pwrite, cts_n, pb} = 7'b0100000;
    paddr = 12'h000;
    pwdata = 32'h0;
    nb = 4'h8;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `CSP_OFF_CTRL, 0, 33'h143);
    apb(0, `CSP_OFF_BAUD, 0, 33'h87a);
    apb(0, `CSP_OFF_STAT, 0, 33'h2);
    apb(0, 12'h010, 0, 33'h100000000);
    apb(1, `CSP_OFF_BAUD, 0, 0);
    apb(1, `CSP_OFF_BAUD, 8, 0);
    apb(0, `CSP_OFF_BAUD, 0, 33'h8);
    $display("test registers done");
    for (int i = 0; i < 20; i++) begin
      d = 4'(5 + i % 4);
      p = 3'(i / 4);
      r = 8'($urandom);
      b = r & 8'((9'h1 << d) - 9'h1);
      q = (p == 3'h1) ? ~^b : (p == 3'h2) ? ^b : (p == 3'h3);
      nb <= d;
      pb <= (p != 3'h0);
      apb(1, `CSP_OFF_CTRL, {23'h0, 3'h5, p, 1'b0, 2'(d - 5)}, 0);
      ser_q.push_back(9'(b) | (9'(q) << d));
      apb(1, `CSP_OFF_DATA, {24'h0, r}, 0);
      wait_ser();
    end
    $display("test frame formats done");
    nb <= 4'h8;
    pb <= 1'b0;
    cts_n <= 1'b1;
    apb(1, `CSP_OFF_CTRL, 32'h143, 0);
    for (int i = 0; i < 17; i++) begin
      r = 8'($urandom);
      if (i < 16) ser_q.push_back({1'b0, r});
      apb(1, `CSP_OFF_DATA, {24'h0, r}, 0);
    end
    apb(0, `CSP_OFF_STAT, 0, 33'h3);
    cts_n <= 1'b0;
    wait_ser();
    cts_n <= 1'b1;
    apb(1, `CSP_OFF_CTRL, 32'h043, 0);
    ser_q.push_back(9'h0a5);
    apb(1, `CSP_OFF_DATA, 32'ha5, 0);
    apb(0, `CSP_OFF_STAT, 0, 33'h3);
    cts_n <= 1'b0;
    wait_ser();
    $display("test buffering done");
    apb(1, `CSP_OFF_CTRL, 32'h043, 0);
    r = 8'($urandom);
    csp_partner_inst.send(r);
    @(posedge pclk);
    chk(33'h1, {32'h0, rts_n});
    apb(0, `CSP_OFF_DATA, 0, {25'h0, r});
    apb(0, `CSP_OFF_STAT, 0, 33'h2);
    chk(33'h0, {32'h0, rts_n});
    apb(1, `CSP_OFF_CTRL, 32'h183, 0);
    csp_partner_inst.send(`CSP_XOFF);
    apb(0, `CSP_OFF_STAT, 0, 33'h42);
    ser_q.push_back(9'h05a);
    apb(1, `CSP_OFF_DATA, 32'h5a, 0);
    repeat (300) @(posedge pclk);
    chk(33'h1, 33'(ser_q.size()));
    csp_partner_inst.send(`CSP_XON);
    wait_ser();
    // Seven-bit frame meets the partner's low eighth bit as its stop
    apb(1, `CSP_OFF_CTRL, 32'h002, 0);
    csp_partner_inst.send(8'h00);
    apb(0, `CSP_OFF_STAT, 0, 33'h12);
    // Even parity meets the partner's stop bit; second byte overruns
    apb(1, `CSP_OFF_CTRL, 32'h013, 0);
    repeat (2) begin
      csp_partner_inst.send(8'h03);
      repeat (10) @(posedge pclk);
    end
    apb(0, `CSP_OFF_STAT, 0, 33'h3c);
    apb(1, `CSP_OFF_STAT, 32'h38, 0);
    apb(0, `CSP_OFF_DATA, 0, 33'h03);
    apb(0, `CSP_OFF_STAT, 0, 33'h2);
    $display("test receive and pause done");
    test_done();
  end
endmodule
`default_nettype wire
